// ---- design/gpio_delay_serdes_io.sv ----
// pad logic for one high-voltage pad and one high-speed pad pair used as gpio
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_io_regs.svh"
module gpio_delay_serdes_io
  import gpio_io_pkg::*;
#(
  parameter int HV_STEPS = `HV_STEPS,
  parameter int HS_SE_STEPS = `HS_SE_STEPS,
  parameter int HS_DIFF_STEPS = `HS_DIFF_STEPS,
  parameter int DYN_STEPS = `DYN_STEPS,
  parameter int HS_IN_DEPTH = `HS_SE_STEPS + `DYN_STEPS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // register and serial clocks from the core, sampled
  input wire logic launch_register_clock,
  input wire logic capture_register_clock,
  input wire logic launch_serial_clock,
  input wire logic capture_serial_clock,
  // high-voltage pad, core side
  input wire logic [1:0] hv_out,
  input wire logic hv_oe,
  output logic [1:0] hv_in,
  // high-speed pad pair, core side, index 0 positive leg
  input wire logic [1:0][3:0] hs_out,
  input wire logic [1:0] hs_oe,
  input wire logic drive_enable_neg_copy,
  output logic [1:0][3:0] hs_in,
  // dynamic delay stepping, one per high-speed pad
  input wire logic [1:0] delay_step_enable,
  input wire logic [1:0] delay_step_direction,
  input wire logic [1:0] delay_counter_clear,
  // bypass paths
  output logic hv_pll_ref,
  output logic global_clock_net,
  output logic pll_ref_clk,
  output logic regional_clock_net,
  output logic pll_external_feedback,
  output logic vref_level,
  // pads
  input wire logic hv_pad_i,
  output logic hv_pad_o,
  output logic hv_pad_oe,
  input wire logic [1:0] hs_pad_i,
  output logic [1:0] hs_pad_o,
  output logic [1:0] hs_pad_oe
);
  localparam int LANES = `LANE_COUNT;
  localparam int SW = `SEL_WIDTH;

  typedef struct packed {
    ctrl_t ctrl;
    static_dly_t sdly;
    clk_seen_t seen;
    logic [LANES-1:0][3:0] core_in;
    logic [LANES-1:0] neg_hold;
    logic [LANES-1:0][3:0] in_shift;
    logic [LANES-1:0][3:0] out_word;
    logic [LANES-1:0][3:0] out_shift;
    logic [LANES-1:0] drive;
    logic [LANES-1:0] oe_held;
    logic [LANES-1:0] pad_oe;
    logic [5:0] bypass;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } top_state_t;

  top_state_t st;
  top_state_t next_st;

  logic lrc_rise;
  logic lrc_fall;
  logic crc_rise;
  logic crc_fall;
  logic lsc_rise;
  logic csc_rise;
  logic access;
  logic [LANES-1:0] pad_raw;
  logic [LANES-1:0] din;
  logic [LANES-1:0] tx_bit;
  logic [LANES-1:0] pad_dly;
  logic [LANES-1:0][3:0] lane_src;
  logic [LANES-1:0] lane_oe;
  logic [LANES-1:0][SW-1:0] in_sel;
  logic [LANES-1:0][SW-1:0] out_sel;
  logic [1:0][5:0] dyn;

  // dynamic delay counters for the two high-speed pads
  for (genvar d = 0; d < 2; d++)
  begin : g_dyn
    delay_stepper #(
      .STEPS(DYN_STEPS),
      .W(6),
      .INIT(`DYN_INIT)
    ) u_step (
      .core_clk(core_clk),
      .rstn(rstn),
      .step_en(delay_step_enable[d]),
      .step_up(delay_step_direction[d]),
      .clear(delay_counter_clear[d]),
      .setting(dyn[d])
    );
  end

  // lane 0 is the high-voltage pad, lanes 1 and 2 the pair
  for (genvar k = 0; k < LANES; k++)
  begin : g_lane
    tap_delay #(
      .DEPTH(k == 0 ? HV_STEPS : HS_IN_DEPTH),
      .SEL_W(SW)
    ) u_in_dly (
      .core_clk(core_clk),
      .rstn(rstn),
      .sel(in_sel[k]),
      .din(pad_raw[k]),
      .dout(din[k])
    );
    tap_delay #(
      .DEPTH(k == 0 ? HV_STEPS : HS_DIFF_STEPS),
      .SEL_W(SW)
    ) u_out_dly (
      .core_clk(core_clk),
      .rstn(rstn),
      .sel(out_sel[k]),
      .din(tx_bit[k]),
      .dout(pad_dly[k])
    );
  end

  always_comb
  begin
    next_st = st;
    pad_raw = {hs_pad_i, hv_pad_i};
    lane_src = {hs_out[1], hs_out[0], {2'b00, hv_out}};
    lane_oe = {hs_oe[1], hs_oe[0], hv_oe};
    if (st.ctrl.diff)
    begin
      lane_oe[2] = drive_enable_neg_copy;
    end

    lrc_rise = launch_register_clock & ~st.seen.lrc;
    lrc_fall = ~launch_register_clock & st.seen.lrc;
    crc_rise = capture_register_clock & ~st.seen.crc;
    crc_fall = ~capture_register_clock & st.seen.crc;
    lsc_rise = launch_serial_clock & ~st.seen.lsc;
    csc_rise = capture_serial_clock & ~st.seen.csc;
    next_st.seen.lrc = launch_register_clock;
    next_st.seen.crc = capture_register_clock;
    next_st.seen.lsc = launch_serial_clock;
    next_st.seen.csc = capture_serial_clock;

    // input delay selects; single-ended pads see only 16 static steps
    in_sel[0] = SW'(st.sdly.hv_in);
    if (st.ctrl.diff)
    begin
      // static and dynamic never stack on the differential receiver
      if (st.ctrl.dyn_sel)
        in_sel[1] = SW'(dyn[0]);
      else
        in_sel[1] = SW'(st.sdly.p_in);
      in_sel[2] = '0;
    end
    else
    begin
      in_sel[1] = SW'(st.sdly.p_in[3:0]) + SW'(dyn[0]);
      in_sel[2] = SW'(st.sdly.n_in) + SW'(dyn[1]);
    end

    // output delay selects carry static steps only
    out_sel[0] = SW'(st.sdly.hv_out);
    if (st.ctrl.diff)
    begin
      out_sel[1] = SW'(st.sdly.p_out);
      out_sel[2] = SW'(st.sdly.p_out);
    end
    else
    begin
      out_sel[1] = SW'(st.sdly.p_out[3:0]);
      out_sel[2] = SW'(st.sdly.n_out);
    end

    for (int k = 0; k < LANES; k++)
    begin
      // capture side, timed by the capture clocks
      if (k != 0 && st.ctrl.ser_in)
      begin
        if (csc_rise)
        begin
          next_st.in_shift[k] = {din[k], st.in_shift[k][3:1]};
        end
        if (crc_rise)
        begin
          next_st.core_in[k] = st.in_shift[k];
        end
      end
      else if (st.ctrl.dual_edge_io_in)
      begin
        if (crc_rise)
        begin
          next_st.core_in[k][0] = din[k];
          next_st.core_in[k][3:2] = 2'b00;
          if (st.ctrl.resync)
            next_st.core_in[k][1] = st.neg_hold[k];
        end
        if (crc_fall)
        begin
          next_st.neg_hold[k] = din[k];
          if (!st.ctrl.resync)
            next_st.core_in[k][1] = din[k];
        end
      end
      else if (crc_rise)
      begin
        next_st.core_in[k] = {3'b000, din[k]};
      end
      if (k == 2 && st.ctrl.diff)
      begin
        next_st.core_in[k] = 4'h0;
      end

      // launch side, timed by the launch clocks
      if (k != 0 && st.ctrl.ser_out)
      begin
        if (lsc_rise)
        begin
          next_st.drive[k] = st.out_shift[k][0];
          next_st.out_shift[k] = {1'b0, st.out_shift[k][3:1]};
        end
        // a load on the same cycle as a shift wins; the word restarts
        if (lrc_rise)
        begin
          next_st.out_shift[k] = lane_src[k];
        end
      end
      else if (st.ctrl.dual_edge_io_out)
      begin
        if (lrc_rise)
        begin
          next_st.out_word[k] = lane_src[k];
          next_st.drive[k] = lane_src[k][0];
        end
        if (lrc_fall)
        begin
          next_st.drive[k] = st.out_word[k][1];
        end
      end
      else if (lrc_rise)
      begin
        next_st.drive[k] = lane_src[k][0];
      end

      if (lrc_rise)
      begin
        next_st.oe_held[k] = lane_oe[k];
      end
      if (st.ctrl.oe_reg)
        next_st.pad_oe[k] = st.oe_held[k];
      else
        next_st.pad_oe[k] = lane_oe[k];
    end

    // the negative leg gets the complement through its own delay line
    tx_bit = st.drive ^ {LANES{st.ctrl.invert}};
    if (st.ctrl.diff)
    begin
      tx_bit[2] = ~tx_bit[1];
    end

    // bypass paths are unregistered at the pad; one flop keeps outputs clean
    next_st.bypass[0] = hv_pad_i;
    for (int r = 0; r < 5; r++)
    begin
      next_st.bypass[r + 1] = st.ctrl.route[r] & hs_pad_i[0];
    end

    // apb: one wait state, write commits on the completing edge
    access = psel & penable;
    next_st.pready = access & ~st.pready;
    if (access && !st.pready)
    begin
      next_st.pslverr = 1'b0;
      next_st.prdata = 32'h00000000;
      if (paddr == `CTRL_OFFSET)
        next_st.prdata = 32'(st.ctrl);
      else if (paddr == `STATIC_DLY_OFFSET)
        next_st.prdata = 32'(st.sdly);
      else if (paddr == `DYN_STATUS_OFFSET)
        next_st.prdata = {18'h00000, dyn[1], 2'b00, dyn[0]};
      else
        next_st.pslverr = 1'b1;
    end
    else
    begin
      // error flag stands only with the one-cycle ready pulse
      next_st.pslverr = 1'b0;
    end
    if (access && st.pready && pwrite)
    begin
      if (paddr == `CTRL_OFFSET)
        next_st.ctrl = ctrl_t'(pwdata[`CTRL_WIDTH-1:0]);
      else if (paddr == `STATIC_DLY_OFFSET)
        next_st.sdly = static_dly_t'(pwdata[`STATIC_DLY_WIDTH-1:0]);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      st <= '0;
      st.ctrl <= ctrl_t'(`CTRL_RESET);
      st.sdly <= static_dly_t'(`STATIC_DLY_RESET);
    end
    else
    begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign hv_in = st.core_in[0][1:0];
  assign hs_in[0] = st.core_in[1];
  assign hs_in[1] = st.core_in[2];
  assign hv_pll_ref = st.bypass[0];
  assign global_clock_net = st.bypass[1];
  assign pll_ref_clk = st.bypass[2];
  assign regional_clock_net = st.bypass[3];
  assign pll_external_feedback = st.bypass[4];
  assign vref_level = st.bypass[5];
  assign hv_pad_o = pad_dly[0];
  assign hs_pad_o = pad_dly[2:1];
  assign hv_pad_oe = st.pad_oe[0];
  assign hs_pad_oe = st.pad_oe[2:1];
endmodule
`default_nettype wire

// ---- include/gpio_io_regs.svh ----
// register offsets, reset values and step counts for the pad logic block
`ifndef GPIO_IO_REGS_SVH
`define GPIO_IO_REGS_SVH

`define CTRL_OFFSET 12'h000
`define STATIC_DLY_OFFSET 12'h004
`define DYN_STATUS_OFFSET 12'h008

`define CTRL_WIDTH 14
`define STATIC_DLY_WIDTH 28
`define CTRL_RESET 14'h0000
`define STATIC_DLY_RESET 28'h0000000

`define HV_STEPS 16
`define HS_SE_STEPS 16
`define HS_DIFF_STEPS 64
`define DYN_STEPS 64
`define DYN_INIT 6'h00
`define LANE_COUNT 3
`define SEL_WIDTH 7

`endif

// ---- include/gpio_io_pkg.sv ----
// types shared by the pad logic block
package gpio_io_pkg;

  // control word, lsb first: diff, dual_edge_io_in, dual_edge_io_out, resync, ser_in, ser_out,
  // oe_reg, invert, dyn_sel, route[4:0]
  typedef struct packed {
    logic [4:0] route;
    logic dyn_sel;
    logic invert;
    logic oe_reg;
    logic ser_out;
    logic ser_in;
    logic resync;
    logic dual_edge_io_out;
    logic dual_edge_io_in;
    logic diff;
  } ctrl_t;

  // static delay word, msb first
  typedef struct packed {
    logic [3:0] n_out;
    logic [3:0] n_in;
    logic [5:0] p_out;
    logic [5:0] p_in;
    logic [3:0] hv_out;
    logic [3:0] hv_in;
  } static_dly_t;

  typedef struct packed {
    logic lrc;
    logic crc;
    logic lsc;
    logic csc;
  } clk_seen_t;

endpackage

// ---- design/tap_delay.sv ----
// selectable tap delay line with a registered output
`timescale 1ns/1ps
`default_nettype none
module tap_delay #(
  parameter int DEPTH = 16,
  parameter int SEL_W = 7
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // data
  input wire logic [SEL_W-1:0] sel,
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic [DEPTH-1:0] taps;
    logic dout;
  } tap_state_t;

  tap_state_t st;
  tap_state_t next_st;

  always_comb
  begin
    next_st.taps = {st.taps[DEPTH-2:0], din};
    next_st.dout = din;
    // each step adds one cycle; out-of-range selects fall back to no delay
    if (sel != '0 && int'(sel) <= DEPTH)
    begin
      next_st.dout = st.taps[int'(sel) - 1];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      st <= '0;
    else
      st <= next_st;
  end

  assign dout = st.dout;
endmodule
`default_nettype wire

// ---- design/delay_stepper.sv ----
// dynamic delay setting, stepped up or down, saturating at both ends
`timescale 1ns/1ps
`default_nettype none
module delay_stepper #(
  parameter int STEPS = 64,
  parameter int W = 6,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // stepping
  input wire logic step_en,
  input wire logic step_up,
  input wire logic clear,
  output logic [W-1:0] setting
);
  logic [W-1:0] st;
  logic [W-1:0] next_st;

  always_comb
  begin
    next_st = st;
    if (clear)
    begin
      next_st = INIT;
    end
    else if (step_en)
    begin
      if (step_up && st != W'(STEPS - 1))
        next_st = st + W'(1);
      else if (!step_up && st != '0)
        next_st = st - W'(1);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      st <= INIT;
    else
      st <= next_st;
  end

  assign setting = st;
endmodule
`default_nettype wire

// ---- verif/gpio_io_props.sv ----
// port-level checker for the pad logic block
`timescale 1ns/1ps
`default_nettype none
module gpio_io_props (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // capture side
  input wire logic capture_register_clock,
  input wire logic [1:0] hv_in,
  input wire logic [1:0][3:0] hs_in,
  // bypass paths
  input wire logic hv_pad_i,
  input wire logic [1:0] hs_pad_i,
  input wire logic hv_pll_ref,
  input wire logic global_clock_net,
  input wire logic pll_ref_clk,
  input wire logic regional_clock_net,
  input wire logic pll_external_feedback,
  input wire logic vref_level
);
  logic [3:0] cap_hist;
  logic cap_recent;
  logic hs_alt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  always_ff @(posedge core_clk)
  begin
    cap_hist <= {cap_hist[2:0], capture_register_clock};
  end
  // captured data may lag the sampled clock change by up to three cycles
  assign cap_recent = (cap_hist != 4'h0) && (cap_hist != 4'hF);
  assign hs_alt = global_clock_net | pll_ref_clk | regional_clock_net;
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held too long");
  property p_ready_wait; psel && $rose(penable) |=> pready; endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("no answer after one wait");
  property p_ready_cause; pready |-> $past(psel && penable); endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("pready without access");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  property p_err_data; pready && pslverr |-> prdata == 32'h00000000; endproperty
  a_err_data: assert property (p_err_data) else $error("error read returned data");
  property p_hv_alt; $past(rstn) |-> hv_pll_ref == $past(hv_pad_i); endproperty
  a_hv_alt: assert property (p_hv_alt) else $error("hv bypass mismatch");
  property p_hs_alt;
    $past(rstn) && (hs_alt | pll_external_feedback | vref_level) |-> $past(hs_pad_i[0]);
  endproperty
  a_hs_alt: assert property (p_hs_alt) else $error("hs bypass not from pad");
  property p_hv_cap; $past(rstn) && $changed(hv_in) |-> cap_recent; endproperty
  a_hv_cap: assert property (p_hv_cap) else $error("hv input moved off capture");
  property p_hs_cap; $past(rstn) && $changed(hs_in[0]) |-> cap_recent; endproperty
  a_hs_cap: assert property (p_hs_cap) else $error("hs input moved off capture");
  c_err: cover property (pready && pslverr);
  c_alt: cover property (global_clock_net);
  c_dual_edge_io: cover property (hv_in == 2'b10);
endmodule
bind gpio_delay_serdes_io gpio_io_props u_props (.core_clk, .rstn, .psel, .penable, .prdata,
  .pready, .pslverr, .capture_register_clock, .hv_in, .hs_in, .hv_pad_i, .hs_pad_i, .hv_pll_ref,
  .global_clock_net, .pll_ref_clk, .regional_clock_net, .pll_external_feedback, .vref_level);
`default_nettype wire

// ---- verif/fabric_model.sv ----
// core fabric stand-in: register and serial clocks, negated-side enable
`timescale 1ns/1ps
`default_nettype none
module fabric_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // control
  input wire logic run,
  input wire logic oe_primary,
  // to the block
  output logic launch_register_clock,
  output logic capture_register_clock,
  output logic launch_serial_clock,
  output logic capture_serial_clock,
  output logic drive_enable_neg_copy
);
  logic [3:0] phase;
  // clocks freeze when stopped; phase steps once per core cycle, so serial clock levels last two core cycles and stay sampleable
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      phase <= 4'h0;
    else if (run)
      phase <= phase + 4'h1;
  end
  assign launch_register_clock = phase[3];
  assign capture_register_clock = phase[3];
  assign launch_serial_clock = phase[1];
  assign capture_serial_clock = phase[1];
  assign drive_enable_neg_copy = oe_primary;
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking bench for the pad logic block
`timescale 1ns/1ps
`default_nettype none
module testbench
  import gpio_io_pkg::*;
;
  logic core_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rv, wd;
  logic pready, pslverr, ev, hv_oe = 1'b0, hv_pad_i = 1'b0, mirror = 1'b0, serial = 1'b0, pa, pb;
  logic [3:0] w4 = 4'h0, x4 = 4'h0;
  logic launch_register_clock, capture_register_clock, launch_serial_clock, capture_serial_clock;
  logic drive_enable_neg_copy, hv_pll_ref, global_clock_net, pll_ref_clk, regional_clock_net;
  logic pll_external_feedback, vref_level, hv_pad_o, hv_pad_oe;
  logic [1:0] hv_out = 2'h0, hs_oe = 2'h0, hs_pad_i = 2'h0, hv_in, hs_pad_o, hs_pad_oe, en, up, cl;
  logic [1:0] delay_step_enable = 2'h0, delay_step_direction = 2'h0, delay_counter_clear = 2'h0;
  logic [1:0][3:0] hs_out = 8'h00, hs_in;
  logic [5:0] m0 = 6'h00, m1 = 6'h00;
  logic [13:0] cfg [4] = '{14'h0040, 14'h0080, 14'h0004, 14'h0001};
  int num_errors = 0, cmp_count = 0, seed = 49786, ones, mism;
  gpio_delay_serdes_io dut (.core_clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .launch_register_clock, .capture_register_clock, .launch_serial_clock,
    .capture_serial_clock, .hv_out, .hv_oe, .hv_in, .hs_out, .hs_oe, .drive_enable_neg_copy,
    .hs_in, .delay_step_enable, .delay_step_direction, .delay_counter_clear, .hv_pll_ref,
    .global_clock_net, .pll_ref_clk, .regional_clock_net, .pll_external_feedback, .vref_level,
    .hv_pad_i, .hv_pad_o, .hv_pad_oe, .hs_pad_i, .hs_pad_o, .hs_pad_oe);
  fabric_model fab (.core_clk, .rstn, .run, .oe_primary(hs_oe[0]), .launch_register_clock,
    .capture_register_clock, .launch_serial_clock, .capture_serial_clock, .drive_enable_neg_copy);
  always #2 core_clk = ~core_clk;
  // pad follows the capture clock phase: low phase shows pa, high phase pb
  always @(posedge core_clk)
  begin
    if (mirror)
    begin
      hv_pad_i <= capture_register_clock ? pb : pa;
      hs_pad_i <= capture_register_clock ? {pb, pb} : {pa, pa};
    end
    else if (serial)
    begin
      // bit j is on the pad in the slot that the j-th serial capture samples
      hs_pad_i <= {1'b0, x4[2'(fab.phase[3:2] + 2'd2)]};
    end
  end
  function automatic logic [5:0] step(logic [5:0] v, logic e, logic u, logic c);
    if (c)
      return 6'h00;
    if (!e)
      return v;
    if (u)
      return (v == 6'h3F) ? v : v + 6'h01;
    return (v == 6'h00) ? v : v - 6'h01;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
      num_errors++;
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge core_clk);
    penable <= 1'b1;
    // request stands until pready is sampled high at a rising edge
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      num_errors++;
      summarize();
    end
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    apb(a, 1'b0, 32'h00000000);
    check(rv, x, "read data");
    check(32'(ev), 32'(xe), "error flag");
  endtask
  task automatic dyn(input int n, input bit forced);
    for (int i = 0; i < n; i++)
    begin
      @(posedge core_clk);
      en = forced ? 2'b11 : 2'($random(seed));
      up = forced ? 2'b01 : 2'($random(seed));
      cl = forced ? 2'b00 : {$random(seed) % 16 == 0, $random(seed) % 16 == 0};
      delay_step_enable <= en;
      delay_step_direction <= up;
      delay_counter_clear <= cl;
      m0 = step(m0, en[0], up[0], cl[0]);
      m1 = step(m1, en[1], up[1], cl[1]);
    end
    @(posedge core_clk);
    {delay_step_enable, delay_step_direction, delay_counter_clear} <= 6'h00;
    rd(12'h008, {18'h0, m1, 2'b00, m0}, 1'b0);
  endtask
  initial
  begin
    repeat (20) @(posedge core_clk);
    check({hv_in, hs_in, hs_pad_oe, hv_pad_oe, pready}, 0, "outputs in reset");
    rstn <= 1'b1;
    run <= 1'b1;
    for (int i = 0; i < 3; i++)
      rd(12'(4 * i), 0, 1'b0);
    wd = $random(seed);
    apb(12'h000, 1'b1, wd);
    rd(12'h000, wd & 32'h00003FFF, 1'b0);
    apb(12'h004, 1'b1, wd);
    rd(12'h004, wd & 32'h0FFFFFFF, 1'b0);
    apb(12'h008, 1'b1, wd);
    rd(12'h008, 0, 1'b0);
    apb(12'h00C, 1'b1, wd);
    check(32'(ev), 1, "unmapped write");
    rd(12'h001, 0, 1'b1);
    apb(12'h000, 1'b1, 0);
    apb(12'h004, 1'b1, 0);
    $display("test registers done");
    dyn(70, 1'b1);
    dyn(400, 1'b0);
    dyn(1, 1'b0);
    @(posedge core_clk);
    delay_counter_clear <= 2'b11;
    {m0, m1} = 12'h000;
    dyn(1, 1'b0);
    $display("test dynamic delay done");
    for (int k = 0; k < 3; k++)
    begin
      apb(12'h000, 1'b1, k == 0 ? 32'h00003E00 : (k == 1 ? 32'h00000002 : 32'h0000000A));
      pa = $random(seed);
      pb = ~pa;
      mirror <= 1'b1;
      repeat (64) @(posedge core_clk);
      @(negedge core_clk);
      check(hv_in & (k == 0 ? 2'b01 : 2'b11), {pb, pa} & (k == 0 ? 2'b01 : 2'b11), "hv in");
      check(hs_in[0][1:0] & (k == 0 ? 2'b01 : 2'b11), {pb, pa} & (k == 0 ? 2'b01 : 2'b11), "hs in");
    end
    mirror <= 1'b0;
    $display("test input capture done");
    hv_out <= 2'b01;
    hs_out <= 8'h11;
    hv_oe <= 1'b1;
    hs_oe <= 2'b01;
    for (int k = 0; k < 4; k++)
    begin
      apb(12'h000, 1'b1, 32'(cfg[k]));
      apb(12'h004, 1'b1, $random(seed));
      repeat (48) @(posedge core_clk);
      ones = 0;
      mism = 0;
      repeat (32)
      begin
        @(negedge core_clk);
        ones += hv_pad_o;
        mism += (hs_pad_o[1] === hs_pad_o[0]);
      end
      if (k == 2)
        check(32'(ones > 0 && ones < 32), 1, "dual-edge output");
      else
        check(ones, k == 1 ? 0 : 32, "output level");
      check(hv_pad_oe, 1, "hv enable");
      check(hs_pad_oe, k == 3 ? 2'b11 : 2'b01, "hs enable");
      if (k == 3)
        check(mism, 0, "differential complement");
    end
    $display("test output path done");
    apb(12'h004, 1'b1, 0);
    apb(12'h000, 1'b1, 32'h00000030);
    w4 = 4'($random(seed));
    x4 = 4'($random(seed));
    hs_out <= {4'h0, w4};
    delay_counter_clear <= 2'b11;
    serial <= 1'b1;
    @(posedge core_clk);
    delay_counter_clear <= 2'b00;
    repeat (64) @(posedge core_clk);
    mism = 0;
    repeat (16)
    begin
      @(negedge core_clk);
      // launch at phase 8, first serial bit on the pad from phase 12
      mism += (hs_pad_o[0] !== w4[2'(fab.phase[3:2] + 2'd1)]);
    end
    check(mism, 0, "serializer order");
    check(hs_in[0], x4, "deserializer order");
    serial <= 1'b0;
    $display("test serial path done");
    summarize();
  end
endmodule
`default_nettype wire
